// ---- verilog/fss_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
module fss_sequencer
    import fss_pkg::*;
#(
    parameter int LIST_MAX = LIST_MAX_DEF,
    parameter int NUM_WIN = NUM_WIN_DEF
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic start,
    input wire logic [LIST_MAX*POS_W-1:0] first_pos,
    input wire logic [CNT_W-1:0] first_cnt,
    input wire logic [NUM_WIN*SCORE_W-1:0] scores,
    input wire logic score_valid,
    input wire logic [NUM_WIN*WGT_W-1:0] weights,
    input wire logic [PCT_W-1:0] thresh_pct,
    input wire logic fine_en,
    input wire logic [POS_W-1:0] fine_step,
    input wire logic [CNT_W-1:0] fine_cnt,
    input wire logic [1:0] final_mode,
    input wire logic backlash_en,
    input wire logic [POS_W-1:0] backlash_step,
    input wire logic [POS_W-1:0] range_min,
    input wire logic [POS_W-1:0] range_max,
    input wire logic move_done,
    output logic move_req,
    output logic [POS_W-1:0] move_pos,
    output logic [POS_W-1:0] best_pos,
    output logic busy,
    output logic done,
    output logic [CNT_W-1:0] list_len
);
    localparam logic [CNT_W-1:0] LMAX = CNT_W'(LIST_MAX);
    localparam logic [CNT_W-1:0] WLAST = CNT_W'(NUM_WIN - 1);

    if (LIST_MAX < 2 || LIST_MAX > 31) begin : g_chk_list
        $error("LIST_MAX must be 2..31");
    end
    if (NUM_WIN < 1 || NUM_WIN > 16) begin : g_chk_win
        $error("NUM_WIN must be 1..16");
    end

    fss_state_t state_ff;
    fss_phase_t phase_ff;
    logic [POS_W-1:0] list_ff [LIST_MAX];
    logic [HIST_W-1:0] hist_ff [LIST_MAX];
    logic [CNT_W-1:0] len_ff, first_len_ff, idx_ff, seed_idx_ff;
    logic [CNT_W-1:0] wcnt_ff, pcnt_ff, best_idx_ff, gk_ff, fk_ff;
    logic [CNT_W-1:0] skip_idx_ff, fine_cnt_ff;
    logic [HIST_W-1:0] best_w_ff;
    logic [POS_W-1:0] move_pos_ff, best_pos_ff, cur_ff, step_ff, bl_ff;
    logic [POS_W-1:0] rmin_ff, rmax_ff;
    logic [1:0] mode_ff;
    logic move_req_ff, done_ff, busy_ff, seeded_ff, skip_vld_ff;
    logic fine_en_ff, bl_en_ff, zdone_ff, gstart_ff, fin_last_ff;
    logic signed [SPAN_W-1:0] gpos_ff;

    logic [NUM_WIN-1:0] win_valid;
    logic [CNT_W-1:0] win_pk [NUM_WIN];
    logic seed_now, upd_now, asc, cur_valid, fin_lst;
    logic [CNT_W-1:0] cur_pk, fcnt_lim;
    logic [WGT_W-1:0] cur_w;
    logic [HIST_W-1:0] cur_hist;
    logic [POS_W-1:0] fin_tgt, bl_tgt, gen_val;
    logic signed [SPAN_W-1:0] fstart, off, span;
    logic signed [SPAN_W-1:0] s_best, s_min, s_max;

    // Codes 2 and 3 both finish with a direct move, so no second flyback
    function automatic logic fss_direct(input logic [1:0] m);
        return (m != MODE_RETRACE) && (m != MODE_JUMP);
    endfunction

    // Clamp a wide signed position into the permitted lens range
    function automatic logic [POS_W-1:0] clamp_pos(
        input logic signed [SPAN_W-1:0] v,
        input logic [POS_W-1:0] lo,
        input logic [POS_W-1:0] hi
    );
        logic signed [SPAN_W-1:0] slo, shi;
        slo = SPAN_W'(lo);
        shi = SPAN_W'(hi);
        if (v < slo) begin
            return lo;
        end else if (v > shi) begin
            return hi;
        end
        return v[POS_W-1:0];
    endfunction

    //**************************************************
    // Per-window peak tracking
    //**************************************************
    assign seed_now = (state_ff == S_SCORE) && score_valid && !seeded_ff;
    assign upd_now = (state_ff == S_SCORE) && score_valid && seeded_ff;
    for (genvar w = 0; w < NUM_WIN; w++) begin : g_win
        fss_win_track #(.IDX_W(CNT_W)) u_trk (
            .core_clk(core_clk),
            .reset(reset),
            .seed(seed_now),
            .upd(upd_now),
            .score(scores[w*SCORE_W +: SCORE_W]),
            .idx(idx_ff),
            .thresh_pct(thresh_pct),
            .valid(win_valid[w]),
            .peak_idx(win_pk[w])
        );
    end

    //**************************************************
    // Weight histogram
    //**************************************************
    always_comb begin
        cur_valid = win_valid[wcnt_ff[3:0]];
        cur_pk = win_pk[wcnt_ff[3:0]];
        cur_w = weights[wcnt_ff[3:0]*WGT_W +: WGT_W];
        cur_hist = hist_ff[cur_pk];
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < LIST_MAX; i++) begin
                hist_ff[i] <= '0;
            end
        end else if (state_ff == S_IDLE || state_ff == S_FGEN) begin
            for (int i = 0; i < LIST_MAX; i++) begin
                hist_ff[i] <= '0;
            end
        end else if (state_ff == S_VOTE && cur_valid) begin
            hist_ff[cur_pk] <= cur_hist + HIST_W'(cur_w);
        end
    end

    //**************************************************
    // Fine-scan start and final targets
    //**************************************************
    // Flyback modes approach from the start side, so scan upward;
    // a direct finish arrives from the scan end, so scan downward.
    always_comb begin
        asc = !fss_direct(mode_ff);
        // Signed copies keep a start below zero from wrapping past the limits
        s_best = $signed(SPAN_W'(best_pos_ff));
        s_min = $signed(SPAN_W'(rmin_ff));
        s_max = $signed(SPAN_W'(rmax_ff));
        off = SPAN_W'(step_ff * (fine_cnt_ff >> 1));
        span = (fine_cnt_ff == '0) ? '0
            : SPAN_W'(step_ff * (fine_cnt_ff - 1'b1));
        if (asc) begin
            fstart = s_best - off;
            if (fstart < s_min) fstart = s_min;
            if (fstart + span > s_max) begin
                fstart = s_max - span;
            end
        end else begin
            fstart = s_best + off;
            if (fstart > s_max) fstart = s_max;
            if (fstart - span < s_min) begin
                fstart = s_min + span;
            end
        end
        gen_val = clamp_pos(gpos_ff, rmin_ff, rmax_ff);
        if (cur_ff > best_pos_ff) begin
            bl_tgt = clamp_pos(SPAN_W'(best_pos_ff) - SPAN_W'(bl_ff),
                rmin_ff, rmax_ff);
        end else begin
            bl_tgt = clamp_pos(SPAN_W'(best_pos_ff) + SPAN_W'(bl_ff),
                rmin_ff, rmax_ff);
        end
        if (!bl_en_ff) bl_tgt = best_pos_ff;
        fin_tgt = best_pos_ff;
        fin_lst = 1'b1;
        case (mode_ff)
            MODE_JUMP: begin
                if (fk_ff == '0) begin
                    fin_tgt = list_ff[0];
                    fin_lst = 1'b0;
                end
            end
            MODE_RETRACE: begin
                if (fk_ff == '0) begin
                    fin_tgt = list_ff[0];
                    fin_lst = 1'b0;
                end else if (fk_ff < first_len_ff
                    && list_ff[fk_ff - 1'b1] != best_pos_ff) begin
                    fin_tgt = list_ff[fk_ff];
                    fin_lst = 1'b0;
                end
            end
            default: fin_tgt = bl_tgt;
        endcase
        fcnt_lim = (first_cnt == '0) ? CNT_W'(1)
            : (first_cnt > LMAX) ? LMAX : first_cnt;
    end

    //**************************************************
    // Sequencer
    //**************************************************
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_ff <= S_IDLE;
            phase_ff <= PH_SCAN1;
            for (int i = 0; i < LIST_MAX; i++) list_ff[i] <= '0;
            {len_ff, first_len_ff, idx_ff, seed_idx_ff} <= '0;
            {wcnt_ff, pcnt_ff, best_idx_ff, gk_ff, fk_ff} <= '0;
            {skip_idx_ff, fine_cnt_ff, best_w_ff} <= '0;
            {move_pos_ff, best_pos_ff, cur_ff, step_ff, bl_ff} <= '0;
            {rmin_ff, rmax_ff, mode_ff, gpos_ff} <= '0;
            {move_req_ff, done_ff, busy_ff, seeded_ff} <= '0;
            {skip_vld_ff, fine_en_ff, bl_en_ff, zdone_ff} <= '0;
            {gstart_ff, fin_last_ff} <= '0;
        end else begin
            move_req_ff <= 1'b0;
            done_ff <= 1'b0;
            case (state_ff)
                S_IDLE: if (start) begin
                    for (int i = 0; i < LIST_MAX; i++) begin
                        list_ff[i] <= first_pos[i*POS_W +: POS_W];
                    end
                    len_ff <= fcnt_lim;
                    first_len_ff <= fcnt_lim;
                    idx_ff <= '0;
                    phase_ff <= PH_SCAN1;
                    {seeded_ff, skip_vld_ff} <= 2'h0;
                    mode_ff <= final_mode;
                    fine_en_ff <= fine_en;
                    fine_cnt_ff <= fine_cnt;
                    step_ff <= fine_step;
                    bl_en_ff <= backlash_en;
                    bl_ff <= backlash_step;
                    rmin_ff <= range_min;
                    rmax_ff <= range_max;
                    busy_ff <= 1'b1;
                    state_ff <= S_MOVE;
                end
                S_MOVE: begin
                    move_req_ff <= 1'b1;
                    move_pos_ff <= list_ff[idx_ff];
                    cur_ff <= list_ff[idx_ff];
                    state_ff <= S_WAIT;
                end
                S_WAIT: if (move_done) begin
                    if (phase_ff == PH_FINAL) begin
                        if (fin_last_ff) begin
                            done_ff <= 1'b1;
                            busy_ff <= 1'b0;
                            state_ff <= S_IDLE;
                        end else begin
                            state_ff <= S_FIN;
                        end
                    end else if (skip_vld_ff && idx_ff == skip_idx_ff) begin
                        idx_ff <= idx_ff + 1'b1;
                        state_ff <= S_MOVE;
                    end else begin
                        state_ff <= S_SCORE;
                    end
                end
                S_SCORE: if (score_valid) begin
                    seeded_ff <= 1'b1;
                    if (!seeded_ff) seed_idx_ff <= idx_ff;
                    if (idx_ff + 1'b1 < len_ff) begin
                        idx_ff <= idx_ff + 1'b1;
                        state_ff <= S_MOVE;
                    end else begin
                        wcnt_ff <= '0;
                        state_ff <= S_VOTE;
                    end
                end
                S_VOTE: begin
                    wcnt_ff <= wcnt_ff + 1'b1;
                    if (wcnt_ff == WLAST) begin
                        pcnt_ff <= '0;
                        best_w_ff <= '0;
                        best_idx_ff <= seed_idx_ff;
                        state_ff <= S_PICK;
                    end
                end
                S_PICK: begin
                    if (pcnt_ff < len_ff) begin
                        if (hist_ff[pcnt_ff] > best_w_ff) begin
                            best_w_ff <= hist_ff[pcnt_ff];
                            best_idx_ff <= pcnt_ff;
                        end
                        pcnt_ff <= pcnt_ff + 1'b1;
                    end else begin
                        best_pos_ff <= list_ff[best_idx_ff];
                        if (phase_ff == PH_SCAN1 && fine_en_ff) begin
                            gk_ff <= '0;
                            {zdone_ff, gstart_ff} <= 2'h1;
                            state_ff <= S_FGEN;
                        end else begin
                            phase_ff <= PH_FINAL;
                            fk_ff <= '0;
                            state_ff <= S_FIN;
                        end
                    end
                end
                S_FGEN: begin
                    if (gstart_ff) begin
                        gpos_ff <= fstart;
                        gstart_ff <= 1'b0;
                    end else if (gk_ff == fine_cnt_ff || len_ff == LMAX) begin
                        if (len_ff == first_len_ff) begin
                            phase_ff <= PH_FINAL;
                            fk_ff <= '0;
                            state_ff <= S_FIN;
                        end else begin
                            idx_ff <= first_len_ff;
                            phase_ff <= PH_SCAN2;
                            seeded_ff <= 1'b0;
                            state_ff <= S_MOVE;
                        end
                    end else if (asc && !zdone_ff && gen_val != '0
                        && len_ff + 1'b1 < LMAX) begin
                        list_ff[len_ff] <= '0;
                        skip_idx_ff <= len_ff;
                        skip_vld_ff <= 1'b1;
                        len_ff <= len_ff + 1'b1;
                        zdone_ff <= 1'b1;
                    end else begin
                        list_ff[len_ff] <= gen_val;
                        len_ff <= len_ff + 1'b1;
                        gk_ff <= gk_ff + 1'b1;
                        zdone_ff <= 1'b1;
                        gpos_ff <= asc ? gpos_ff + SPAN_W'(step_ff)
                            : gpos_ff - SPAN_W'(step_ff);
                    end
                end
                default: begin
                    move_req_ff <= 1'b1;
                    move_pos_ff <= fin_tgt;
                    cur_ff <= fin_tgt;
                    fin_last_ff <= fin_lst;
                    fk_ff <= fk_ff + 1'b1;
                    state_ff <= S_WAIT;
                end
            endcase
        end
    end

    assign move_req = move_req_ff;
    assign move_pos = move_pos_ff;
    assign best_pos = best_pos_ff;
    assign busy = busy_ff;
    assign done = done_ff;
    assign list_len = len_ff;

    //**************************************************
    // Checks
    //**************************************************
    property p_fine_gate;
        @(posedge core_clk) disable iff (reset)
        (state_ff == S_FGEN && $past(state_ff) == S_PICK) |->
            $past(fine_en_ff) && $past(phase_ff) == PH_SCAN1;
    endproperty
    a_fine_gate: assert property (p_fine_gate) else $error("fine scan ungated");
    property p_list_max;
        @(posedge core_clk) disable iff (reset)
        len_ff <= LMAX;
    endproperty
    a_list_max: assert property (p_list_max) else $error("list overflow");
    property p_zero_head;
        @(posedge core_clk) disable iff (reset)
        skip_vld_ff |-> list_ff[skip_idx_ff] == '0
            && skip_idx_ff == first_len_ff && !fss_direct(mode_ff);
    endproperty
    a_zero_head: assert property (p_zero_head) else $error("bad lead zero");
    property p_no_zero;
        @(posedge core_clk) disable iff (reset)
        (phase_ff == PH_SCAN2 && fss_direct(mode_ff)) |-> !skip_vld_ff;
    endproperty
    a_no_zero: assert property (p_no_zero) else $error("zero in direct");
    property p_clamp;
        @(posedge core_clk) disable iff (reset)
        (state_ff == S_WAIT && phase_ff == PH_SCAN2 && !skip_vld_ff) |->
            move_pos_ff >= rmin_ff && move_pos_ff <= rmax_ff;
    endproperty
    a_clamp: assert property (p_clamp) else $error("fine pos out of range");
    property p_wait_done;
        @(posedge core_clk) disable iff (reset)
        (state_ff == S_WAIT && !move_done) |=> !move_req_ff;
    endproperty
    a_wait_done: assert property (p_wait_done) else $error("early move");
    property p_no_vote;
        @(posedge core_clk) disable iff (reset)
        ($past(state_ff) == S_PICK && state_ff != S_PICK && best_w_ff == '0)
            |-> best_pos_ff == list_ff[seed_idx_ff];
    endproperty
    a_no_vote: assert property (p_no_vote) else $error("no-vote best wrong");
    property p_invalid;
        @(posedge core_clk) disable iff (reset)
        (state_ff == S_VOTE && !cur_valid) |=>
            hist_ff[$past(cur_pk)] == $past(cur_hist);
    endproperty
    a_invalid: assert property (p_invalid) else $error("invalid vote counted");
    property p_valid;
        @(posedge core_clk) disable iff (reset)
        (state_ff == S_VOTE && cur_valid) |=>
            hist_ff[$past(cur_pk)] == $past(cur_hist) + HIST_W'($past(cur_w));
    endproperty
    a_valid: assert property (p_valid) else $error("weight not added");
    property p_direct;
        @(posedge core_clk) disable iff (reset)
        (state_ff == S_FIN && fss_direct(mode_ff)) |=>
            move_req_ff && move_pos_ff == $past(bl_tgt) && fin_last_ff;
    endproperty
    a_direct: assert property (p_direct) else $error("direct move wrong");
    property p_flyback;
        @(posedge core_clk) disable iff (reset)
        (state_ff == S_FIN && !fss_direct(mode_ff) && fk_ff == '0) |=>
            move_pos_ff == list_ff[0] && !fin_last_ff;
    endproperty
    a_flyback: assert property (p_flyback) else $error("no flyback");
endmodule
`default_nettype wire

// ---- verilog/fss_pkg.sv ----
// Overview of operation
// - Fine scan only when enabled, step-based positions
// - At first-scan end, build fine list
// - Fine list respects range limits, approach direction
// - Flyback modes prepend zero unless list starts zero
// - Direct mode never prepends a zero
// - Fine list appended; total at most 20
// - Fine scan followed by chosen final positioning
// - Flyback to start, then retrace or jump
// - Direct move to best, optional backlash step
// - Low-variation windows add no histogram weight
// - Per-position weight sums valid window weights
// - Largest histogram weight gives best position
// - No valid votes selects scan start position
// - Seed min and max at start; track peak
// - Positions are unsigned 8-bit abstract values
package fss_pkg;
    localparam int POS_W = 8;
    localparam int SCORE_W = 8;
    localparam int WGT_W = 4;
    localparam int HIST_W = 8;
    localparam int CNT_W = 5;
    localparam int LIST_MAX_DEF = 20;
    localparam int NUM_WIN_DEF = 16;
    localparam int PCT_W = 8;
    localparam int SPAN_W = 14;
    localparam logic [6:0] PCT_SCALE = 7'h64;
    localparam logic [1:0] MODE_RETRACE = 2'h0;
    localparam logic [1:0] MODE_JUMP = 2'h1;
    localparam logic [1:0] MODE_DIRECT = 2'h2;
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_MOVE = 3'h1,
        S_WAIT = 3'h3,
        S_SCORE = 3'h2,
        S_VOTE = 3'h6,
        S_PICK = 3'h7,
        S_FGEN = 3'h5,
        S_FIN = 3'h4
    } fss_state_t;
    typedef enum logic [1:0] {
        PH_SCAN1 = 2'h0,
        PH_SCAN2 = 2'h1,
        PH_FINAL = 2'h3
    } fss_phase_t;
endpackage

// ---- verilog/fss_win_track.sv ----
`timescale 1ns/1ps
`default_nettype none
module fss_win_track
    import fss_pkg::*;
#(
    parameter int IDX_W = CNT_W
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic seed,
    input wire logic upd,
    input wire logic [SCORE_W-1:0] score,
    input wire logic [IDX_W-1:0] idx,
    input wire logic [PCT_W-1:0] thresh_pct,
    output logic valid,
    output logic [IDX_W-1:0] peak_idx
);
    logic [SCORE_W-1:0] min_ff;
    logic [SCORE_W-1:0] max_ff;
    logic [IDX_W-1:0] peak_ff;
    logic [15:0] var_scaled;
    logic [15:0] thr_scaled;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            min_ff <= '0;
            max_ff <= '0;
            peak_ff <= '0;
        end else if (seed) begin
            min_ff <= score;
            max_ff <= score;
            peak_ff <= idx;
        end else if (upd) begin
            if (score > max_ff) begin
                max_ff <= score;
                peak_ff <= idx;
            end
            if (score < min_ff) begin
                min_ff <= score;
            end
        end
    end

    // Percentage test without a divider: var*100 >= thr*max
    always_comb begin
        var_scaled = 16'((max_ff - min_ff) * PCT_SCALE);
        thr_scaled = 16'(thresh_pct * max_ff);
        valid = (var_scaled >= thr_scaled);
    end
    assign peak_idx = peak_ff;

    property p_seed;
        @(posedge core_clk) disable iff (reset)
        seed |=> (max_ff == $past(score)) && (min_ff == $past(score))
            && (peak_ff == $past(idx));
    endproperty
    a_seed: assert property (p_seed) else $error("seed not taken");
endmodule
`default_nettype wire

// ---- bench/fss_lens_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fss_lens_model (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] lat,
    input wire logic move_req,
    output logic move_done
);
    logic [7:0] cnt_ff;
    // Settle time is a port so one run can mix prompt and slow moves
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cnt_ff <= 8'h00;
            move_done <= 1'b0;
        end else begin
            move_done <= (cnt_ff == 8'h01);
            if (move_req) begin
                cnt_ff <= lat;
            end else if (cnt_ff != 8'h00) begin
                cnt_ff <= cnt_ff - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ---- bench/tb_fss_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_fss_sequencer;
    import fss_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic start = 1'b0;
    logic score_valid = 1'b0;
    logic [1:0] mode = 2'h0;
    logic bl_en = 1'b0;
    logic fine_en = 1'b0;
    logic [7:0] lat = 8'h01;
    logic [4:0] fcnt = 5'h03;
    logic [7:0] rmax = 8'hFF;
    logic [7:0] len_exp = 8'h03;
    logic [127:0] scores = 128'h0;
    logic [159:0] first_pos = {136'h0, 8'h50, 8'h30, 8'h10};
    logic [63:0] weights = {{15{4'h1}}, 4'h3};
    logic move_req, move_done, busy, done;
    logic seen_ff = 1'b0;
    logic [POS_W-1:0] move_pos, best_pos;
    logic [CNT_W-1:0] list_len;
    logic [POS_W-1:0] mv[$];
    int pk = -1;
    int err_total = 0;
    int comparisons = 0;
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    fss_sequencer u_dut (.core_clk(core_clk), .reset(reset), .start(start),
        .first_pos(first_pos), .first_cnt(5'h03), .scores(scores),
        .score_valid(score_valid), .weights(weights), .thresh_pct(8'h32),
        .fine_en(fine_en), .fine_step(8'h04), .fine_cnt(fcnt),
        .final_mode(mode), .backlash_en(bl_en), .backlash_step(8'h05),
        .range_min(8'h00), .range_max(rmax), .move_done(move_done),
        .move_req(move_req), .move_pos(move_pos), .best_pos(best_pos),
        .busy(busy), .done(done), .list_len(list_len));
    fss_lens_model u_lens (.core_clk(core_clk), .reset(reset), .lat(lat),
        .move_req(move_req), .move_done(move_done));
    // Window 0 peaks at move pk, and at pk+4 in a fine scan;
    // the others stay flat and must not vote
    function automatic logic [127:0] mk(input int k);
        logic [127:0] v;
        v = {16{8'h40}};
        v[7:0] = (k == pk || k == pk + 4) ? 8'hC8 : 8'h20;
        return v;
    endfunction
    always @(posedge core_clk) begin
        if (move_req === 1'b1) mv.push_back(move_pos);
        seen_ff <= (move_done === 1'b1);
    end
    always @(negedge core_clk) begin
        score_valid <= seen_ff;
        scores <= mk(mv.size() - 1);
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic run_search(input logic [1:0] m, input logic b, input int p);
        int n;
        mv.delete();
        pk = p;
        @(negedge core_clk);
        mode = m;
        bl_en = b;
        start = 1'b1;
        @(negedge core_clk);
        start = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 3000) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 3000) err_total++;
        chk({7'h0, busy}, 8'h00);
        chk({3'h0, list_len}, len_exp);
    endtask
    task automatic t_direct;
        lat = 8'h01;
        run_search(2'h2, 1'b0, 2);
        chk(best_pos, 8'h50);
        chk(8'(mv.size()), 8'h04);
        chk(mv[$], 8'h50);
        $display("t_direct done");
    endtask
    task automatic t_backlash;
        lat = 8'h09;
        run_search(2'h3, 1'b1, 0);
        chk(best_pos, 8'h10);
        chk(mv[$], 8'h0B);
        run_search(2'h2, 1'b1, 1);
        chk(best_pos, 8'h30);
        chk(mv[$], 8'h2B);
        $display("t_backlash done");
    endtask
    task automatic t_jump;
        lat = 8'h04;
        run_search(2'h1, 1'b0, 1);
        chk(8'(mv.size()), 8'h05);
        chk(mv[3], 8'h10);
        chk(mv[4], 8'h30);
        $display("t_jump done");
    endtask
    task automatic t_retrace_novote;
        lat = 8'h02;
        run_search(2'h0, 1'b0, -1);
        chk(best_pos, 8'h10);
        chk(8'(mv.size()), 8'h05);
        chk(mv[3], 8'h10);
        run_search(2'h0, 1'b0, 1);
        chk(8'(mv.size()), 8'h06);
        chk(mv[4], 8'h30);
        chk(mv[5], 8'h30);
        $display("t_retrace_novote done");
    endtask
    task automatic t_fine;
        lat = 8'h01;
        fine_en = 1'b1;
        len_exp = 8'h07;
        run_search(2'h1, 1'b0, 1);
        chk(8'(mv.size()), 8'h09);
        chk(mv[3], 8'h00);
        chk(mv[4], 8'h2C);
        chk(mv[6], 8'h34);
        chk(best_pos, 8'h30);
        chk(mv[7], 8'h10);
        chk(mv[8], 8'h30);
        fcnt = 5'h0B;
        len_exp = 8'h0E;
        run_search(2'h1, 1'b0, 0);
        chk(8'(mv.size()), 8'h10);
        chk(mv[3], 8'h00);
        chk(mv[4], 8'h04);
        chk(best_pos, 8'h04);
        chk(mv[15], 8'h04);
        fcnt = 5'h03;
        rmax = 8'h12;
        len_exp = 8'h06;
        run_search(2'h2, 1'b1, 0);
        chk(mv[3], 8'h12);
        chk(best_pos, 8'h0E);
        chk(8'(mv.size()), 8'h07);
        chk(mv[6], 8'h12);
        rmax = 8'hFF;
        fine_en = 1'b0;
        len_exp = 8'h03;
        $display("t_fine done");
    endtask
    initial begin
        // Hang guard: all searches take well under this span
        #200000;
        err_total++;
        give_verdict();
    end
    initial begin
        repeat (4) @(negedge core_clk);
        reset = 1'b0;
        t_direct();
        t_backlash();
        t_jump();
        t_retrace_novote();
        t_fine();
        give_verdict();
    end
endmodule
`default_nettype wire
